// [rtl/acp_pin_if.sv]
/*
 * Carrier of the synchronised serial pin events between the pin stage and
 * the sequencer. Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface acp_pin_if;
    logic cs_low;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic din;

    modport sync (output cs_low, output cs_fall, output cs_rise,
                  output sclk_rise, output sclk_fall, output din);
    modport seq  (input cs_low, input cs_fall, input cs_rise,
                  input sclk_rise, input sclk_fall, input din);
endinterface : acp_pin_if

// [rtl/acp_pin_sync.sv]
/*
 * Two-flop synchronisers for chip select, serial clock and serial data, plus
 * edge detection on the synchronised levels.
 * Assumes the serial clock is far slower than CLK (at least 8 CLK per half period).
 */
`timescale 1ns/1ps
module acp_pin_sync
    import acp_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RST_B,
    input  wire logic cs_b_pin,
    input  wire logic sclk_pin,
    input  wire logic din_pin,
    acp_pin_if.sync   pins
);

    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [1:0] last_reg;

    // Stage one is read only by stage two; edges compare stage two with a third copy.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            meta_reg <= 3'h1;
            sync_reg <= 3'h1;
            last_reg <= 2'h1;
        end else begin
            meta_reg <= {din_pin, sclk_pin, cs_b_pin};
            sync_reg <= meta_reg;
            last_reg <= sync_reg[1:0];
        end
    end

    // Edge pulses last one CLK cycle each.
    assign pins.cs_low    = ~sync_reg[0];
    assign pins.cs_fall   = last_reg[0] & ~sync_reg[0];
    assign pins.cs_rise   = ~last_reg[0] & sync_reg[0];
    assign pins.sclk_rise = ~last_reg[1] & sync_reg[1];
    assign pins.sclk_fall = last_reg[1] & ~sync_reg[1];
    assign pins.din       = sync_reg[2];

endmodule : acp_pin_sync

// [rtl/acp_pkg.sv]
/*
 * Constants of the serial conversion port: frame timing, control byte layout,
 * power mode codes and the wake-up time.
 * Assumes a 100 MHz system clock that oversamples the serial pins.
 */
package acp_pkg;

    // ****************************************************************
    // Frame timing in serial clock edges
    // ****************************************************************
    localparam int unsigned CTRL_BITS   = 8;
    localparam int unsigned FRAME_RISES = 16;
    localparam int unsigned SAMPLE_RISE = 2;
    localparam int unsigned LEAD_ZEROS  = 4;
    localparam int unsigned RES_W       = 12;

    // ****************************************************************
    // Control byte layout and reset value
    // ****************************************************************
    localparam int unsigned CTRL_PM_LO_POS = 0;
    localparam int unsigned CTRL_PM_HI_POS = 1;
    localparam int unsigned CTRL_CHAN_POS  = 2;
    localparam int unsigned CTRL_DUAL_POS  = 3;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;

    // ****************************************************************
    // Power modes
    // ****************************************************************
    typedef enum logic [1:0] {
        PM_CS_CTRL  = 2'b00,
        PM_ALWAYS   = 2'b01,
        PM_SHUTDOWN = 2'b10,
        PM_STANDBY  = 2'b11
    } acp_pm_e;

    // ****************************************************************
    // Wake-up time
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WAKE_TIME_NS  = 5000;
    localparam int unsigned WAKE_CYCLES   = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : acp_pkg

// [rtl/acp_top.sv]
/*
 * Serial port and conversion sequencer of a two-input 12-bit sampling converter.
 * Assumes an external converter core that presents the digitised held value on
 * CONV_RESULT once TRACK_HOLD is high, and a serial master that owns CS_B and SCLK.
 */
// Operation
// - Serial clock edges pace conversion, control input and result output alike.
// - Chip select falling enables the clock, puts sampler in track, may wake.
// - Second rising clock edge after chip select falls samples and starts conversion.
// - Conversion ends fourteen and a half clock periods after the sampling edge; with an idle-high clock the code ends it at select rise instead.
// - Chip select rising releases the serial data output.
// - With chip select held low, a new frame follows a completed one.
// - Sampled input is the one chosen by the previous frame's control byte.
// - Control byte is loaded from data input on the first eight rising edges.
// - Control byte reloads in every frame that reaches the eighth rise; a low data input loads all zeros.
// - One frame of sixteen clocks converts and reads out a result.
// - A falling first edge drives the first leading zero, valid at first rise.
// - A rising first edge may miss the first leading zero; host ignores it.
// - Later output bits change on falling edges for capture on rising edges.
// - Last bit is driven before, and valid at, the sixteenth rising edge.
// - Two power mode bits pick select-controlled, always on, shutdown, or standby.
// - Auto-shutdown modes wake on first falling clock and sleep at conversion end.
`timescale 1ns/1ps
module acp_top
    import acp_pkg::*;
(
    input  wire logic             CLK,
    input  wire logic             RST_B,
    input  wire logic             CS_B,
    input  wire logic             SCLK,
    input  wire logic             DIN,
    output logic                  DOUT,
    output logic                  DOUT_OE,
    input  wire logic [RES_W-1:0] CONV_RESULT,
    output logic                  TRACK_HOLD,
    output logic                  CONV_START,
    output logic                  CONV_DONE,
    output logic                  CHAN_SEL,
    output logic                  DUAL_MODE,
    output logic [1:0]            POWER_MODE,
    output logic                  POWER_ON,
    output logic                  REF_ON,
    output logic                  ANALOG_READY,
    output logic [CTRL_BITS-1:0]  CTRL_VALUE
);

    // ****************************************************************
    // Pin stage
    // ****************************************************************
    acp_pin_if pins ();

    acp_pin_sync u_sync (
        .CLK      (CLK),
        .RST_B    (RST_B),
        .cs_b_pin (CS_B),
        .sclk_pin (SCLK),
        .din_pin  (DIN),
        .pins     (pins.sync)
    );

    // ****************************************************************
    // Frame sequencer
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ  = 2'b01,
        ST_CONV = 2'b10,
        ST_DONE = 2'b11
    } acp_state_e;

    localparam logic [4:0] CNT_SAMPLE = 5'(SAMPLE_RISE);
    localparam logic [4:0] CNT_LAST   = 5'(FRAME_RISES);
    localparam logic [4:0] CNT_CTRL   = 5'(CTRL_BITS);

    acp_state_e           state_reg;
    logic [4:0]           cnt_reg;
    logic [4:0]           cnt_next;
    logic                 hold_reg;
    logic                 start_reg;
    logic                 done_reg;
    logic                 chan_reg;
    logic [RES_W-1:0]     result_reg;
    logic [CTRL_BITS-1:0] shift_reg;
    logic [CTRL_BITS-1:0] ctrl_reg;
    logic [CTRL_BITS-1:0] ctrl_next;
    logic                 rise_live;
    logic                 fall_live;
    logic                 conv_end;

    // A completed frame wraps to edge one of the next frame.
    assign cnt_next  = (cnt_reg == CNT_LAST) ? 5'h01 : cnt_reg + 5'h01;
    assign ctrl_next = {shift_reg[CTRL_BITS-2:0], pins.din};
    assign rise_live = pins.sclk_rise & pins.cs_low & ~pins.cs_fall;
    assign fall_live = pins.sclk_fall & pins.cs_low & ~pins.cs_fall;
    // The sampling edge plus fourteen and a half periods is the fall after rise sixteen;
    // an idle-high clock has no such fall, so a select rise after rise sixteen ends it instead.
    assign conv_end  = (fall_live | pins.cs_rise) & (state_reg == ST_CONV) & (cnt_reg == CNT_LAST);

    // Edges are only counted while chip select is low, which gates the clock.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 5'h00;
        end else if (pins.cs_rise || !pins.cs_low) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 5'h00;
        end else if (pins.cs_fall) begin
            state_reg <= ST_ACQ;
            cnt_reg   <= 5'h00;
        end else if (rise_live) begin
            cnt_reg <= cnt_next;
            if (cnt_next == CNT_SAMPLE) begin
                state_reg <= ST_CONV;
            end else if (cnt_next == 5'h01) begin
                state_reg <= ST_ACQ;
            end
        end else if (conv_end) begin
            state_reg <= ST_DONE;
        end
    end

    // Track/hold and conversion strobes; the channel latch uses last frame's byte.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            hold_reg   <= 1'b0;
            start_reg  <= 1'b0;
            done_reg   <= 1'b0;
            chan_reg   <= 1'b0;
            result_reg <= '0;
        end else begin
            start_reg <= rise_live & (cnt_next == CNT_SAMPLE);
            done_reg  <= conv_end;
            if (rise_live && cnt_next == CNT_SAMPLE) begin
                hold_reg <= 1'b1;
                chan_reg <= ctrl_reg[CTRL_DUAL_POS] & ctrl_reg[CTRL_CHAN_POS];
            end else if (pins.cs_fall || conv_end || !pins.cs_low) begin
                hold_reg <= 1'b0;
            end
            // The core's answer is taken while the input is held.
            if (hold_reg && state_reg == ST_CONV) begin
                result_reg <= CONV_RESULT;
            end
        end
    end

    // ****************************************************************
    // Control byte input
    // ****************************************************************
    // Every frame that reaches the eighth rise overwrites the byte, so a grounded data input reloads zeros.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            shift_reg <= CTRL_RESET;
            ctrl_reg  <= CTRL_RESET;
        end else if (rise_live && cnt_next <= CNT_CTRL) begin
            shift_reg <= ctrl_next;
            if (cnt_next == CNT_CTRL) begin
                ctrl_reg <= ctrl_next;
            end
        end
    end

    // ****************************************************************
    // Result output
    // ****************************************************************
    logic [FRAME_RISES-1:0] out_word;
    logic [3:0]             out_idx;
    logic                   dout_reg;
    logic                   oe_reg;

    assign out_word = {{LEAD_ZEROS{1'b0}}, result_reg};
    assign out_idx  = 4'(CNT_LAST - 5'h01 - cnt_reg);

    // The first zero is set at select fall; a rising first edge may beat it out.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            dout_reg <= 1'b0;
            oe_reg   <= 1'b0;
        end else if (pins.cs_rise || !pins.cs_low) begin
            oe_reg   <= 1'b0;
            dout_reg <= 1'b0;
        end else if (pins.cs_fall) begin
            oe_reg   <= 1'b1;
            dout_reg <= 1'b0;
        end else if (fall_live) begin
            if (cnt_reg != 5'h00 && cnt_reg != CNT_LAST) begin
                dout_reg <= out_word[out_idx];
            end else begin
                dout_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Power management
    // ****************************************************************
    logic       pwr_reg;
    logic [9:0] wake_reg;
    acp_pm_e    pm;
    localparam logic [9:0] WAKE_MAX = 10'(WAKE_CYCLES);

    assign pm = acp_pm_e'({ctrl_reg[CTRL_PM_HI_POS], ctrl_reg[CTRL_PM_LO_POS]});

    // Auto-shutdown modes wake on a fall before conversion ends and sleep at its end.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pwr_reg <= 1'b0;
        end else begin
            case (pm)
                PM_CS_CTRL: pwr_reg <= pins.cs_low;
                PM_ALWAYS:  pwr_reg <= 1'b1;
                PM_SHUTDOWN, PM_STANDBY: begin
                    // A cut frame never raises conversion end, so a select rise also powers down.
                    if (conv_end || pins.cs_rise) begin
                        pwr_reg <= 1'b0;
                    end else if (fall_live && state_reg != ST_DONE) begin
                        pwr_reg <= 1'b1;
                    end
                end
                default: pwr_reg <= 1'b0;
            endcase
        end
    end

    // Settling counter; standby keeps the reference up, so it is ready at once.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            wake_reg <= 10'h000;
        end else if (!pwr_reg) begin
            wake_reg <= 10'h000;
        end else if (wake_reg != WAKE_MAX) begin
            wake_reg <= wake_reg + 10'h001;
        end
    end

    assign DOUT         = dout_reg;
    assign DOUT_OE      = oe_reg;
    assign TRACK_HOLD   = hold_reg;
    assign CONV_START   = start_reg;
    assign CONV_DONE    = done_reg;
    assign CHAN_SEL     = chan_reg;
    assign DUAL_MODE    = ctrl_reg[CTRL_DUAL_POS];
    assign POWER_MODE   = pm;
    assign POWER_ON     = pwr_reg;
    assign REF_ON       = pwr_reg | (pm == PM_STANDBY);
    assign ANALOG_READY = pwr_reg & ((wake_reg == WAKE_MAX) | (pm == PM_STANDBY));
    assign CTRL_VALUE   = ctrl_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_sample_edge;
        rise_live && cnt_reg == 5'h01;
    endsequence

    sequence s_frame_end;
        rise_live && cnt_reg == CNT_LAST;
    endsequence

    AST_OE_RELEASE: assert property (pins.cs_rise |=> !DOUT_OE)
        else $error("Data output still driven after select rose.");
    AST_FRAME_OPEN: assert property (pins.cs_fall |=> DOUT_OE && !TRACK_HOLD && !DOUT)
        else $error("Select fall did not open the frame in track.");
    AST_SAMPLE: assert property (s_sample_edge |=> TRACK_HOLD && CONV_START)
        else $error("Second rising edge did not sample.");
    AST_CONV_END: assert property (CONV_DONE |-> $past(cnt_reg, 1) == CNT_LAST && !TRACK_HOLD)
        else $error("Conversion ended at the wrong edge.");
    AST_CTRL_LOAD: assert property (rise_live && cnt_reg == 5'h07 |=> ctrl_reg == $past(ctrl_next))
        else $error("Control byte not loaded at eighth rising edge.");
    AST_CHAN_PREV: assert property (CONV_START |-> CHAN_SEL == (DUAL_MODE & ctrl_reg[CTRL_CHAN_POS]))
        else $error("Sampled channel differs from previous selection.");
    AST_WRAP: assert property (s_frame_end |=> cnt_reg == 5'h01 && state_reg == ST_ACQ)
        else $error("Held select did not start a new frame.");
    AST_LEAD_ZERO: assert property (fall_live && cnt_reg < 5'(LEAD_ZEROS) |=> !DOUT)
        else $error("Leading zero not driven.");
    AST_ALWAYS_ON: assert property (pm == PM_ALWAYS ##1 pm == PM_ALWAYS |-> POWER_ON)
        else $error("Always-on mode powered down.");
    AST_AUTO_OFF: assert property (conv_end && pm[1] |=> !POWER_ON)
        else $error("Auto-shutdown mode stayed powered.");

endmodule : acp_top

// [sim/acp_host_model.sv]
/*
 * Serial master model: drives select, serial clock and data into the port and
 * captures the returned word. Assumes a 100 MHz bench clock; a serial half
 * period is 8 CLK, so the serial clock period is 160 ns.
 */
`timescale 1ns/1ps
module acp_host_model (
    input  wire logic clk,
    input  wire logic dout,
    input  wire logic dout_oe,
    output logic      cs_b,
    output logic      sclk,
    output logic      din
);
    logic [1:0] pm_now;
    logic       line;

    // A released data line shows the inverse level, so a stale bit never passes.
    assign line = dout_oe ? dout : ~dout;

    // ****************************************************************
    // Idle state
    // ****************************************************************
    // The serial clock stands still outside frames.
    initial begin
        cs_b   = 1'h1;
        sclk   = 1'h0;
        din    = 1'h0;
        pm_now = 2'h0;
    end

    // ****************************************************************
    // One frame
    // ****************************************************************
    // Drives one frame; the clock idles high for the second clock style.
    task automatic frame(input logic [7:0] ctrl, input bit idle_hi, input int nrise, input int gap,
                         input bit keep, output logic [15:0] word);
        int acq;
        // Wake-up modes get the acquisition stretched past the wake time.
        acq = (pm_now == 2'h0 || pm_now == 2'h2) ? 510 : 0;
        word = 16'h0000;
        // The idle level is set while select is high, so only idle-high frames open with a fall.
        @(negedge clk);
        sclk = idle_hi;
        repeat (8) @(negedge clk);
        cs_b = 1'h0;
        repeat (8) @(negedge clk);
        sclk = 1'h0;
        for (int i = 0; i < nrise; i++) begin
            din = (i < 8) ? ctrl[7-i] : ~din;
            repeat (8 + ((i == 1) ? acq : 0)) @(negedge clk);
            word = {word[14:0], line};
            sclk = 1'h1;
            repeat (8 + ((i == 7) ? gap : 0)) @(negedge clk);
            if (!(idle_hi && i == nrise - 1)) begin
                sclk = 1'h0;
            end
        end
        repeat (8) @(negedge clk);
        if (nrise >= 8) begin
            pm_now = ctrl[1:0];
        end
        if (!keep) begin
            cs_b = 1'h1;
            sclk = idle_hi;
            din  = ~din;
        end
        repeat (8) @(negedge clk);
    endtask : frame
endmodule : acp_host_model

// [sim/acp_top_tb.sv]
/*
 * Self-checking bench of the serial conversion port: reset, table of frames,
 * then split, back-to-back and abort cases. Assumes the host model drives
 * the serial pins and the bench stands in for the converter core.
 */
`timescale 1ns/1ps
module acp_top_tb
    import acp_pkg::*;
;
    typedef struct {logic [7:0] ctrl; logic [11:0] res; bit hi;} acp_row_s;

    logic             clk, rst_b, cs_b, sclk, din, dout, dout_oe;
    logic [RES_W-1:0] conv_result;
    logic             track_hold, conv_start, conv_done, chan_sel, dual_mode;
    logic [1:0]       power_mode;
    logic             power_on, ref_on, analog_ready;
    logic [7:0]       ctrl_value, prev;
    logic [15:0]      w;
    int               fail_count, checks_done, starts, dones, span, last_span, s0, d0;
    acp_row_s         rows[8] = '{'{8'h01, 12'hA5C, 0}, '{8'h0D, 12'h3F0, 0}, '{8'h09, 12'hFFF, 0},
                                  '{8'h06, 12'h001, 1}, '{8'h02, 12'h800, 0}, '{8'h03, 12'h555, 0},
                                  '{8'hF0, 12'h7E1, 0}, '{8'h00, 12'h000, 0}};

    acp_top dut (.CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk), .DIN(din), .DOUT(dout),
                 .DOUT_OE(dout_oe), .CONV_RESULT(conv_result), .TRACK_HOLD(track_hold),
                 .CONV_START(conv_start), .CONV_DONE(conv_done), .CHAN_SEL(chan_sel),
                 .DUAL_MODE(dual_mode), .POWER_MODE(power_mode), .POWER_ON(power_on), .REF_ON(ref_on),
                 .ANALOG_READY(analog_ready), .CTRL_VALUE(ctrl_value));
    acp_host_model host (.clk(clk), .dout(dout), .dout_oe(dout_oe), .cs_b(cs_b), .sclk(sclk), .din(din));

    // ****************************************************************
    // Clock, monitors and reporting
    // ****************************************************************
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Counts conversions and the CLK span from start pulse to done pulse.
    always @(posedge clk) begin
        span = (conv_start === 1'h1) ? 0 : span + 1;
        starts = starts + ((conv_start === 1'h1) ? 1 : 0);
        if (conv_done === 1'h1) begin
            dones++;
            last_span = span;
        end
    end

    // Compares one value and reports a difference at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        wrap_up();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    // Reset first, then the table of frames and the awkward cases by hand.
    initial begin
        rst_b = 1'h0;
        conv_result = 12'h000;
        repeat (8) @(negedge clk);
        check(16'({dout_oe, track_hold, power_on, ref_on, analog_ready, ctrl_value}), 16'h0000);
        rst_b = 1'h1;
        $display("reset test done");
        prev = 8'h00;
        for (int i = 0; i < 8; i++) begin
            conv_result = rows[i].res;
            s0 = starts;
            d0 = dones;
            host.frame(rows[i].ctrl, rows[i].hi, 16, 0, 0, w);
            if (rows[i].hi) begin
                check(w, {4'h0, rows[i].res});
            end else begin
                check(w & 16'h7FFF, {4'h0, rows[i].res});
                check(16'(last_span), 16'((2 * (FRAME_RISES - SAMPLE_RISE) + 1) * 8));
            end
            check(16'(dones - d0), 16'h0001);
            check(16'({power_on, ref_on}), 16'({rows[i].ctrl[1:0] == 2'h1, rows[i].ctrl[0]}));
            check(16'(ctrl_value), 16'(rows[i].ctrl));
            check(16'({dual_mode, power_mode}), 16'({rows[i].ctrl[3], rows[i].ctrl[1:0]}));
            check(16'(chan_sel), 16'(prev[3] & prev[2]));
            check(16'(dout_oe), 16'h0000);
            check(16'(starts - s0), 16'h0001);
            prev = rows[i].ctrl;
            $display("row %0d done", i);
        end
        // Two frames with select held low, the first split into two bytes.
        conv_result = 12'h9C3;
        d0 = dones;
        host.frame(8'h01, 0, 16, 40, 1, w);
        check(w & 16'h7FFF, 16'h09C3);
        check(16'(dout_oe), 16'h0001);
        conv_result = 12'h36A;
        host.frame(8'h01, 0, 16, 0, 0, w);
        check(w & 16'h7FFF, 16'h036A);
        check(16'({dones - d0, track_hold}), 16'h0004);
        $display("back to back test done");
        // Aborted frames: no sample on one rise, none of the byte loaded.
        for (int n = 1; n < 6; n += 4) begin
            s0 = starts;
            host.frame(8'hFE, 0, n, 0, 0, w);
            check(16'(starts - s0), 16'(n >= 2));
            check(16'({ctrl_value, dout_oe}), 16'h0002);
        end
        $display("abort test done");
        repeat (520) @(negedge clk);
        check(16'({power_on, analog_ready}), 16'h0003);
        $display("power test done");
        wrap_up();
    end
endmodule : acp_top_tb
